// ===== pkg/fcw_pkg.sv
// Constants and carrier types for the codec write register bank
package fcw_pkg;

	// ****************************************
	// Bus widths
	// ****************************************
	localparam int FCW_DATA_W = 8; // Processor data bus width
	localparam int FCW_ADDR_W = 5; // Processor address bus width
	localparam int FCW_BER_W = 24; // Error rate period, three bytes

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [4:0] FCW_A_METRIC_LOW = 5'h00; // Metric middle and low bits
	localparam logic [4:0] FCW_A_METRIC_SECTOR = 5'h01; // Sector and metric high bits
	localparam logic [4:0] FCW_A_DEC_FIXED = 5'h02; // Fixed decoder control
	localparam logic [4:0] FCW_A_DEC_MODE = 5'h03; // Decoder mode control
	localparam logic [4:0] FCW_A_DEC_RESET = 5'h04; // Decoder reset control
	localparam logic [4:0] FCW_A_ENC_DATA = 5'h05; // Encoder data input
	localparam logic [4:0] FCW_A_ENC_RESET = 5'h06; // Encoder reset control
	localparam logic [4:0] FCW_A_ENC_MODE = 5'h07; // Encoder mode control
	localparam logic [4:0] FCW_A_TEST_LEN = 5'h08; // Sync test length
	localparam logic [4:0] FCW_A_TEST_THR = 5'h09; // Sync test threshold
	localparam logic [4:0] FCW_A_BER_LS = 5'h0a; // Error period low byte
	localparam logic [4:0] FCW_A_BER_CS = 5'h0b; // Error period middle byte
	localparam logic [4:0] FCW_A_BER_MS = 5'h0c; // Error period high byte
	localparam logic [4:0] FCW_A_DEC_IN_STB = 5'h0e; // Decoder input clock strobe
	localparam logic [4:0] FCW_A_DEC_OUT_STB = 5'h0f; // Decoder output clock strobe
	localparam logic [4:0] FCW_A_ENC_IN_STB = 5'h11; // Encoder input clock strobe
	localparam logic [4:0] FCW_A_ENC_OUT_STB = 5'h12; // Encoder output clock strobe
	localparam logic [4:0] FCW_A_SYNC_APPLY = 5'h17; // Sync test apply and restart
	localparam logic [4:0] FCW_A_BER_APPLY = 5'h18; // Error test apply and restart

	// ****************************************
	// Field positions
	// ****************************************
	localparam int FCW_B_PERIPH = 3; // Peripheral versus direct data
	localparam int FCW_B_DIFF = 4; // Differential and resolver enable
	localparam int FCW_B_PSK = 7; // Eight or sixteen phase select
	localparam int FCW_B_DEC_RST = 2; // Decoder software reset
	localparam int FCW_B_ENC_RST = 1; // Encoder software reset

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] FCW_RST_BYTE = 8'h00; // Plain register reset
	localparam logic [7:0] FCW_RST_DEC_FIXED = 8'hc0; // Fixed ones in bits 6 and 7
	localparam logic [23:0] FCW_RST_BER = 24'h000000; // Error period reset

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic cs_n; // Chip select, active low
		logic wr_n; // Write strobe, active low
		logic [4:0] addr; // Register address
		logic [7:0] data; // Write data
	} fcw_bus_t;

	typedef struct packed {
		logic [2:0] m11; // Metric one_one
		logic [2:0] m01; // Metric zero_one
		logic [2:0] m10; // Metric one_zero
		logic [2:0] m00; // Metric zero_zero
		logic [3:0] sector; // Sector number
	} fcw_metric_t;

	typedef enum logic [1:0] {
		FCW_ST_IDLE = 2'b01, // Waiting for a write strobe
		FCW_ST_HELD = 2'b10 // Strobe still low, write already taken
	} fcw_state_t;

endpackage : fcw_pkg

// ===== hw/fcw_regbank.sv
// Write-only control register bank of the convolutional codec
`timescale 1ns/10ps
`default_nettype none

module fcw_regbank #(
	parameter int DATA_W = 8, // Processor data width
	parameter int ADDR_W = 5 // Processor address width
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire fcw_pkg::fcw_bus_t bus_in,
	input wire fcw_pkg::fcw_metric_t metric_pins,
	input wire logic [2:0] encoder_pin_bits,
	input wire logic decoder_symbol_in_clock_pin,
	input wire logic decoder_data_out_clock_pin,
	input wire logic encoder_data_in_clock_pin,
	input wire logic encoder_symbol_out_clock_pin,
	input wire logic decoder_reset_pin,
	input wire logic encoder_reset_pin,
	output logic decoder_symbol_in_clock,
	output logic decoder_data_out_clock,
	output logic encoder_data_in_clock,
	output logic encoder_symbol_out_clock,
	output var fcw_pkg::fcw_metric_t metric_out,
	output logic [2:0] encoder_input_bits,
	output logic decoder_peripheral,
	output logic encoder_peripheral,
	output logic diff_decoder_enable,
	output logic diff_encoder_enable,
	output logic decoder_psk8_select,
	output logic encoder_psk16_select,
	output logic decoder_reset,
	output logic encoder_reset,
	output logic [7:0] sync_test_length,
	output logic [7:0] sync_test_threshold,
	output logic sync_test_restart,
	output logic [23:0] error_period,
	output logic error_test_restart
);
	import fcw_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (DATA_W != FCW_DATA_W) begin : g_bad_data
		$error("Data width must be eight");
	end
	if (ADDR_W != FCW_ADDR_W) begin : g_bad_addr
		$error("Address width must be five");
	end

	// ****************************************
	// Bus write detection
	// ****************************************
	fcw_state_t state_r; // Strobe tracker
	fcw_state_t state_nxt; // Next tracker state
	logic strobe_low; // Chip select and write both low
	logic wr_take; // One cycle per host write

	// Both strobes low forms a write
	assign strobe_low = !bus_in.cs_n && !bus_in.wr_n;

	// Take the write only on the first low cycle
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FCW_ST_IDLE: begin
				if (strobe_low) begin
					state_nxt = FCW_ST_HELD;
				end
			end
			FCW_ST_HELD: begin
				if (!strobe_low) begin
					state_nxt = FCW_ST_IDLE;
				end
			end
			default: begin
				state_nxt = FCW_ST_IDLE;
			end
		endcase
	end

	assign wr_take = strobe_low && (state_r == FCW_ST_IDLE);

	// Tracker state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= FCW_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Address hit helper
	function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
		hit = (a == want);
	endfunction : hit

	// ****************************************
	// Stored control registers
	// ****************************************
	logic [7:0] metric_low_r; // Middle and low metric bits
	logic [7:0] metric_sector_r; // Sector and metric high bits
	logic [7:0] dec_fixed_r; // Fixed decoder control
	logic [7:0] dec_mode_r; // Decoder mode control
	logic [7:0] dec_reset_r; // Decoder reset control
	logic [7:0] enc_mode_r; // Encoder mode control
	logic [7:0] enc_reset_r; // Encoder reset control
	logic [2:0] enc_data_r; // Encoder data from the bus
	logic [7:0] len_stage_r; // Test length waiting to apply
	logic [7:0] thr_stage_r; // Threshold waiting to apply
	logic [23:0] ber_stage_r; // Error period waiting to apply

	// Plain control registers written from the bus
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			metric_low_r <= FCW_RST_BYTE;
			metric_sector_r <= FCW_RST_BYTE;
			dec_fixed_r <= FCW_RST_DEC_FIXED;
			dec_mode_r <= FCW_RST_BYTE;
			enc_mode_r <= FCW_RST_BYTE;
		end else if (wr_take) begin
			if (hit(bus_in.addr, FCW_A_METRIC_LOW)) begin
				metric_low_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_METRIC_SECTOR)) begin
				metric_sector_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_DEC_FIXED)) begin
				dec_fixed_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_DEC_MODE)) begin
				dec_mode_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_ENC_MODE)) begin
				enc_mode_r <= bus_in.data;
			end
		end
	end

	// Encoder data only accepted in peripheral mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			enc_data_r <= 3'h0;
		end else if (wr_take && hit(bus_in.addr, FCW_A_ENC_DATA) && enc_mode_r[FCW_B_PERIPH]) begin
			enc_data_r <= bus_in.data[2:0];
		end
	end

	// Staging for the monitor test values
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			len_stage_r <= FCW_RST_BYTE;
			thr_stage_r <= FCW_RST_BYTE;
			ber_stage_r <= FCW_RST_BER;
		end else if (wr_take) begin
			if (hit(bus_in.addr, FCW_A_TEST_LEN)) begin
				len_stage_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_TEST_THR)) begin
				thr_stage_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_BER_LS)) begin
				ber_stage_r[7:0] <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_BER_CS)) begin
				ber_stage_r[15:8] <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_BER_MS)) begin
				ber_stage_r[23:16] <= bus_in.data;
			end
		end
	end

	// ****************************************
	// Software resets
	// ****************************************
	logic dec_sw_rise; // Decoder reset bit goes 0 to 1
	logic enc_sw_rise; // Encoder reset bit goes 0 to 1

	assign dec_sw_rise = wr_take && hit(bus_in.addr, FCW_A_DEC_RESET)
		&& bus_in.data[FCW_B_DEC_RST] && !dec_reset_r[FCW_B_DEC_RST];
	assign enc_sw_rise = wr_take && hit(bus_in.addr, FCW_A_ENC_RESET)
		&& bus_in.data[FCW_B_ENC_RST] && !enc_reset_r[FCW_B_ENC_RST];

	// Reset control registers keep the last value to see edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_reset_r <= FCW_RST_BYTE;
			enc_reset_r <= FCW_RST_BYTE;
		end else if (wr_take) begin
			if (hit(bus_in.addr, FCW_A_DEC_RESET)) begin
				dec_reset_r <= bus_in.data;
			end
			if (hit(bus_in.addr, FCW_A_ENC_RESET)) begin
				enc_reset_r <= bus_in.data;
			end
		end
	end

	// Reset outputs merge the pin with the software edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			decoder_reset <= 1'b0;
			encoder_reset <= 1'b0;
		end else begin
			decoder_reset <= decoder_reset_pin || dec_sw_rise;
			encoder_reset <= encoder_reset_pin || enc_sw_rise;
		end
	end

	// ****************************************
	// Software clock strobes
	// ****************************************
	// Any data value gives one pulse; pin is held low by the host
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			decoder_symbol_in_clock <= 1'b0;
			decoder_data_out_clock <= 1'b0;
			encoder_data_in_clock <= 1'b0;
			encoder_symbol_out_clock <= 1'b0;
		end else begin
			decoder_symbol_in_clock <= decoder_symbol_in_clock_pin
				|| (wr_take && hit(bus_in.addr, FCW_A_DEC_IN_STB));
			decoder_data_out_clock <= decoder_data_out_clock_pin
				|| (wr_take && hit(bus_in.addr, FCW_A_DEC_OUT_STB));
			encoder_data_in_clock <= encoder_data_in_clock_pin
				|| (wr_take && hit(bus_in.addr, FCW_A_ENC_IN_STB));
			encoder_symbol_out_clock <= encoder_symbol_out_clock_pin
				|| (wr_take && hit(bus_in.addr, FCW_A_ENC_OUT_STB));
		end
	end

	// ****************************************
	// Monitor test apply and restart
	// ****************************************
	logic sync_apply; // Write to the sync apply strobe
	logic ber_apply; // Write to the error apply strobe

	assign sync_apply = wr_take && hit(bus_in.addr, FCW_A_SYNC_APPLY);
	assign ber_apply = wr_take && hit(bus_in.addr, FCW_A_BER_APPLY);

	// Active values change only on an apply write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_test_length <= FCW_RST_BYTE;
			sync_test_threshold <= FCW_RST_BYTE;
			sync_test_restart <= 1'b0;
			error_period <= FCW_RST_BER;
			error_test_restart <= 1'b0;
		end else begin
			sync_test_restart <= sync_apply;
			error_test_restart <= ber_apply;
			if (sync_apply) begin
				sync_test_length <= len_stage_r;
				sync_test_threshold <= thr_stage_r;
			end
			if (ber_apply) begin
				error_period <= ber_stage_r;
			end
		end
	end

	// ****************************************
	// Mode outputs and data routing
	// ****************************************
	fcw_metric_t metric_bus; // Metrics as written over the bus

	// Unpack metric registers into fields
	always_comb begin
		metric_bus.m00 = {metric_sector_r[4], metric_low_r[0], metric_low_r[4]};
		metric_bus.m10 = {metric_sector_r[5], metric_low_r[1], metric_low_r[5]};
		metric_bus.m01 = {metric_sector_r[6], metric_low_r[2], metric_low_r[6]};
		metric_bus.m11 = {metric_sector_r[7], metric_low_r[3], metric_low_r[7]};
		metric_bus.sector = metric_sector_r[3:0];
	end

	// Registered mode and data outputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			metric_out <= '0;
			encoder_input_bits <= 3'h0;
			decoder_peripheral <= 1'b0;
			encoder_peripheral <= 1'b0;
			diff_decoder_enable <= 1'b0;
			diff_encoder_enable <= 1'b0;
			decoder_psk8_select <= 1'b0;
			encoder_psk16_select <= 1'b0;
		end else begin
			decoder_peripheral <= dec_mode_r[FCW_B_PERIPH];
			encoder_peripheral <= enc_mode_r[FCW_B_PERIPH];
			metric_out <= dec_mode_r[FCW_B_PERIPH] ? metric_bus : metric_pins;
			encoder_input_bits <= enc_mode_r[FCW_B_PERIPH] ? enc_data_r : encoder_pin_bits;
			diff_decoder_enable <= dec_mode_r[FCW_B_DIFF];
			diff_encoder_enable <= enc_mode_r[FCW_B_DIFF];
			decoder_psk8_select <= dec_mode_r[FCW_B_PSK];
			encoder_psk16_select <= enc_mode_r[FCW_B_PSK];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_dec_in_one;
		wr_take && bus_in.addr == FCW_A_DEC_IN_STB && !decoder_symbol_in_clock_pin
			##1 !decoder_symbol_in_clock_pin && !strobe_low
		|-> decoder_symbol_in_clock ##1 !decoder_symbol_in_clock;
	endproperty
	a_dec_in_one: assert property (p_dec_in_one) else $error("Decoder input strobe not one cycle");

	property p_dec_out_one;
		wr_take && bus_in.addr == FCW_A_DEC_OUT_STB
		|=> decoder_data_out_clock ##1 decoder_data_out_clock == $past(decoder_data_out_clock_pin);
	endproperty
	a_dec_out_one: assert property (p_dec_out_one) else $error("Decoder output strobe not one cycle");

	property p_enc_in_one;
		decoder_symbol_in_clock_pin == 1'b0 && encoder_data_in_clock_pin == 1'b0 && state_r == FCW_ST_HELD
		|=> !encoder_data_in_clock;
	endproperty
	a_enc_in_one: assert property (p_enc_in_one) else $error("Encoder input strobe repeated in one write");

	property p_enc_out_one;
		wr_take && bus_in.addr == FCW_A_ENC_OUT_STB
		|=> encoder_symbol_out_clock ##1 encoder_symbol_out_clock == $past(encoder_symbol_out_clock_pin);
	endproperty
	a_enc_out_one: assert property (p_enc_out_one) else $error("Encoder output strobe not one cycle");

	property p_sync_apply;
		sync_apply |=> sync_test_restart && sync_test_length == $past(len_stage_r)
			&& sync_test_threshold == $past(thr_stage_r);
	endproperty
	a_sync_apply: assert property (p_sync_apply) else $error("Sync test values not applied");

	property p_ber_hold;
		!ber_apply |=> $stable(error_period) && !error_test_restart;
	endproperty
	a_ber_hold: assert property (p_ber_hold) else $error("Error period changed without apply");

	property p_dec_rst_edge;
		dec_sw_rise |=> decoder_reset;
	endproperty
	a_dec_rst_edge: assert property (p_dec_rst_edge) else $error("Decoder software reset lost");

	property p_enc_rst_quiet;
		!enc_sw_rise && !encoder_reset_pin |=> !encoder_reset;
	endproperty
	a_enc_rst_quiet: assert property (p_enc_rst_quiet) else $error("Spurious encoder reset");

	property p_psk_polarity;
		wr_take && bus_in.addr == FCW_A_ENC_MODE ##2 1'b1 |-> encoder_psk16_select == $past(bus_in.data[FCW_B_PSK], 2);
	endproperty
	a_psk_polarity: assert property (p_psk_polarity) else $error("Encoder phase select wrong");

	property p_enc_data;
		wr_take && bus_in.addr == FCW_A_ENC_DATA && enc_mode_r[FCW_B_PERIPH] ##1 enc_mode_r[FCW_B_PERIPH]
		|=> encoder_input_bits == $past(bus_in.data[2:0], 2);
	endproperty
	a_enc_data: assert property (p_enc_data) else $error("Encoder bus data not routed");

	c_dec_strobe: cover property (wr_take && bus_in.addr == FCW_A_DEC_IN_STB ##1 decoder_symbol_in_clock);
	c_sync_apply: cover property (sync_apply ##1 sync_test_restart);
	c_dec_reset: cover property (dec_sw_rise ##1 decoder_reset);
	c_periph: cover property (encoder_peripheral && decoder_peripheral);

endmodule : fcw_regbank

`default_nettype wire

// ===== tb/fcw_host_model.sv
// Host processor model driving the codec register write bus
`timescale 1ns/10ps
`default_nettype none

module fcw_host_model (
	input wire logic clk,
	output var fcw_pkg::fcw_bus_t bus_out,
	output logic [3:0] clk_pins
);
	import fcw_pkg::*;

	// Hardware clock pins parked low while strobes clock the codec
	assign clk_pins = 4'h0;

	// Forces every fixed and reserved bit to its required value
	function automatic logic [7:0] fix_bits(input logic [4:0] a, input logic [7:0] d);
		case (a)
			5'h02: return 8'hc0;
			5'h03: return (d & 8'h98) | 8'h01;
			5'h04: return (d & 8'hf4) | 8'h01;
			5'h05: return d & 8'h07;
			5'h06: return (d & 8'h02) | 8'h84;
			5'h07: return d & 8'h98;
			5'h15, 5'h16: return 8'h00;
			default: return d;
		endcase
	endfunction : fix_bits

	// Idle bus: strobes high, address and data lines zero
	initial bus_out = '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 8'h00};

	// One write; strobes held low for hold cycles, then released
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d, input int hold);
		@(posedge clk);
		bus_out <= '{cs_n: 1'b0, wr_n: 1'b0, addr: a, data: fix_bits(a, d)};
		repeat (hold) @(posedge clk);
		bus_out <= '{cs_n: 1'b1, wr_n: 1'b1, addr: ~a, data: ~fix_bits(a, d)};
	endtask : write_reg

endmodule : fcw_host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the codec write register bank
`timescale 1ns/10ps
`default_nettype none

module tb;
	import fcw_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	fcw_bus_t bus;
	logic [3:0] clk_pins;
	fcw_metric_t metric_pins = 16'h1234; // Direct-mode decoder pins
	logic [2:0] encoder_pin_bits = 3'h2; // Direct-mode encoder pins
	logic decoder_reset_pin = 1'b0; // Low while software reset used
	logic encoder_reset_pin = 1'b0; // Low while software reset used
	logic dsi, ddo, edi, eso, ddif, ediff, dp, ep, d8, e16, drst, erst, srst, brst;
	fcw_metric_t metric_out;
	logic [2:0] enc_bits;
	logic [7:0] tlen, tthr;
	logic [23:0] eper;
	logic [7:0] pv; // Pulse outputs
	logic [31:0] pcnt = 32'h0; // Four-bit pulse counts
	logic [31:0] exp_cnt = 32'h0; // Expected pulse counts
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [4:0] r_addr [5] = '{5'h03, 5'h03, 5'h07, 5'h07, 5'h03};
	logic [7:0] r_data [5] = '{8'h88, 8'h10, 8'h08, 8'h90, 8'h98};
	logic [5:0] r_obs [5] = '{6'h22, 6'h08, 6'h18, 6'h0d, 6'h2f};
	logic [4:0] s_addr [4] = '{5'h0e, 5'h0f, 5'h11, 5'h12};
	logic [7:0] s_data [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
	wire [5:0] obs = {dp, ep, ddif, ediff, d8, e16};

	assign pv = {brst, srst, erst, drst, eso, edi, ddo, dsi};

	// ****************************************
	// Clock, pulse counting, timeout
	// ****************************************
	always #5 clk = ~clk;

	// Counts high cycles of every pulse output, idle in reset so no unknown creeps in
	always @(posedge clk) begin
		if (!sys_rst) begin
			for (int i = 0; i < 8; i++) begin
				pcnt[i*4 +: 4] <= pcnt[i*4 +: 4] + 4'(pv[i]);
			end
		end
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			wrap_up();
		end
	end

	fcw_host_model u_fcw_host_model (.clk(clk), .bus_out(bus), .clk_pins(clk_pins));

	fcw_regbank u_fcw_regbank (
		.clk(clk), .sys_rst(sys_rst), .bus_in(bus), .metric_pins(metric_pins),
		.encoder_pin_bits(encoder_pin_bits), .decoder_symbol_in_clock_pin(clk_pins[0]),
		.decoder_data_out_clock_pin(clk_pins[1]), .encoder_data_in_clock_pin(clk_pins[2]),
		.encoder_symbol_out_clock_pin(clk_pins[3]), .decoder_reset_pin(decoder_reset_pin),
		.encoder_reset_pin(encoder_reset_pin), .decoder_symbol_in_clock(dsi), .decoder_data_out_clock(ddo),
		.encoder_data_in_clock(edi), .encoder_symbol_out_clock(eso), .metric_out(metric_out),
		.encoder_input_bits(enc_bits), .decoder_peripheral(dp), .encoder_peripheral(ep),
		.diff_decoder_enable(ddif), .diff_encoder_enable(ediff), .decoder_psk8_select(d8),
		.encoder_psk16_select(e16), .decoder_reset(drst), .encoder_reset(erst), .sync_test_length(tlen),
		.sync_test_threshold(tthr), .sync_test_restart(srst), .error_period(eper), .error_test_restart(brst)
	);

	// ****************************************
	// Tasks
	// ****************************************
	// Compares one value and counts it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Write, then wait n edges and settle
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input int n);
		u_fcw_host_model.write_reg(a, d, 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : wr

	// Prints the counts and the verdict
	task automatic wrap_up();
		$display("checks=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (19) @(posedge clk);
		#1;
		check(32'({obs, pv, tlen, enc_bits}), 32'h0);
		check(32'(metric_out), 32'h0);
		@(posedge clk);
		sys_rst <= 1'b0;
		$display("test reset done");
		// Mode rows
		for (int i = 0; i < 5; i++) begin
			wr(r_addr[i], r_data[i], 2);
			check(32'(obs), 32'(r_obs[i]));
		end
		$display("test mode rows done");
		// Any value, held strobe gives a single clock
		for (int i = 0; i < 4; i++) begin
			u_fcw_host_model.write_reg(s_addr[i], s_data[i], i + 1);
			exp_cnt = exp_cnt + (32'h1 << (4 * i));
			repeat (3) @(posedge clk);
			#1;
			check(pcnt, exp_cnt);
		end
		$display("test strobes done");
		// Staged test values apply only on the apply write
		wr(5'h08, 8'h3c, 0);
		wr(5'h09, 8'ha5, 2);
		check(32'({tlen, tthr}), 32'h0);
		wr(5'h17, 8'h00, 0);
		check(32'({tlen, tthr, 7'h0, srst}), 32'h3ca501);
		wr(5'h08, 8'hff, 0);
		wr(5'h17, 8'h77, 3);
		check(32'({tlen, tthr}), 32'hffa5);
		wr(5'h0a, 8'h11, 0);
		wr(5'h0b, 8'h22, 0);
		wr(5'h0c, 8'h33, 2);
		check(32'(eper), 32'h0);
		wr(5'h18, 8'hff, 0);
		check(32'({brst, eper}), 32'h1332211);
		exp_cnt = exp_cnt + 32'h12000000;
		$display("test apply done");
		// Pin resets while the software bits are still zero
		@(posedge clk);
		decoder_reset_pin <= 1'b1;
		encoder_reset_pin <= 1'b1;
		@(posedge clk);
		decoder_reset_pin <= 1'b0;
		encoder_reset_pin <= 1'b0;
		// Software resets on rising edges only, pins now low
		wr(5'h04, 8'h04, 0);
		wr(5'h04, 8'h04, 0);
		wr(5'h04, 8'h00, 0);
		wr(5'h04, 8'h04, 0);
		wr(5'h06, 8'h02, 0);
		exp_cnt = exp_cnt + 32'h00230000;
		wr(5'h14, 8'hff, 0);
		wr(5'h15, 8'h00, 3);
		check(pcnt, exp_cnt);
		check(32'(obs), 32'h2f);
		$display("test resets done");
		// Metric routing, bus then pins
		wr(5'h00, 8'h5a, 0);
		wr(5'h01, 8'hc9, 2);
		check(32'(metric_out), 32'hd519);
		wr(5'h03, 8'h00, 3);
		check(32'(metric_out), 32'h1234);
		// Encoder data, bus then pins, refused while direct
		wr(5'h07, 8'h08, 0);
		wr(5'h05, 8'h05, 2);
		check(32'(enc_bits), 32'h5);
		wr(5'h07, 8'h00, 0);
		wr(5'h05, 8'h02, 3);
		check(32'(enc_bits), 32'h2);
		wr(5'h07, 8'h08, 3);
		check(32'(enc_bits), 32'h5);
		$display("test routing done");
		// Second reset in mid-run
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		#1;
		check(32'({obs, tlen, eper[15:0]}), 32'h0);
		// Release again: pins route through, first write lands
		@(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		check(32'(metric_out), 32'h1234);
		wr(5'h0e, 8'h3c, 0);
		check(32'(dsi), 32'h1);
		$display("test mid reset done");
		wrap_up();
	end

endmodule : tb
`default_nettype wire
